/* File: src/arc_top.sv */
`timescale 1ns/100ps
`include "arc_defines.svh"
module arc_top
  import arc_pkg::*;
(
  input  wire logic        CLK_IN,
  input  wire logic        RESETN_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic      [31:0] HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  input  wire logic        HW_TRIGGER_IN,
  input  wire logic        CONV_DONE_IN,
  input  wire logic [9:0]  CONV_RESULT_IN,
  output logic             CONV_START_OUT,
  output logic             CONV_ABORT_OUT,
  output logic             CONV_ACTIVE_OUT,
  output logic      [4:0]  CHANNEL_OUT,
  output logic             MODE_TEN_OUT
);

  function automatic logic mode_ten(input logic [1:0] m);
    mode_ten = (m == `ARC_MODE_10);
  endfunction

  function automatic logic cmp_met(input logic [9:0] res,
                                   input logic [1:0] cvh,
                                   input logic [7:0] cvl,
                                   input logic       ten,
                                   input logic       ge);
    logic [9:0] r;
    logic [9:0] v;
    r = ten ? res : {2'h0, res[7:0]};
    v = ten ? {cvh, cvl} : {2'h0, cvl};
    if (ge) begin
      cmp_met = (r >= v);
    end else begin
      cmp_met = (r < v);
    end
  endfunction

  arc_req_t   req_q;
  logic       dphase_q;
  arc_ctl_t   ctl_q;
  logic [4:0] ch_q;
  logic [1:0] mode_q;
  logic       ten_q;
  logic [1:0] cvh_q;
  logic [7:0] cvl_q;
  logic [9:0] res_q;
  logic       done_flag_q;
  logic       lock_q;
  logic       active_q;
  logic       start_q;
  logic       abort_q;
  logic [31:0] rdata_q;
  logic       trig_s1_q;
  logic       trig_s2_q;
  logic       trig_s3_q;

  logic       ten;
  logic       addr_ok;
  logic [7:0] a_addr;
  logic       rd_now;
  logic       rd_hi;
  logic       rd_lo;
  logic       wr_sc1;
  logic       wr_sc2;
  logic       wr_cfg;
  logic       sw_go;
  logic       hw_edge;
  logic       hw_go;
  logic       go;
  logic       done_ok;
  logic       met;
  logic       load;
  logic       xfer;
  logic [31:0] rd_mux;

  assign ten     = mode_ten(mode_q);
  assign addr_ok = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
  assign a_addr  = HADDR_IN[7:0];
  assign rd_now  = addr_ok && !HWRITE_IN;
  assign rd_hi   = rd_now && (a_addr == `ARC_OFF_RH);
  assign rd_lo   = rd_now && (a_addr == `ARC_OFF_RL);
  assign wr_sc1  = dphase_q && req_q.wr && (req_q.addr == `ARC_OFF_SC1);
  assign wr_sc2  = dphase_q && req_q.wr && (req_q.addr == `ARC_OFF_SC2);
  assign wr_cfg  = dphase_q && req_q.wr && (req_q.addr == `ARC_OFF_CFG);

  assign sw_go   = wr_sc1 && !ctl_q.tsel && (HWDATA_IN[4:0] != `ARC_CH_OFF);
  assign hw_edge = trig_s2_q && !trig_s3_q;
  assign hw_go   = hw_edge && ctl_q.tsel && !wr_sc1 && (ch_q != `ARC_CH_OFF);
  assign go      = sw_go || hw_go;
  assign done_ok = CONV_DONE_IN && active_q && !wr_sc1;

  assign met  = cmp_met(CONV_RESULT_IN, cvh_q, cvl_q, ten, ctl_q.ge);
  assign load = done_ok && (!ctl_q.cmp_en || met);
  assign xfer = load && !(lock_q && ten);

  always_comb begin
    rd_mux = 32'h0;
    case (a_addr)
      `ARC_OFF_SC1: rd_mux = {24'h0, done_flag_q, 2'h0, ch_q};
      `ARC_OFF_SC2: rd_mux = {24'h0, active_q, ctl_q, 4'h0};
      `ARC_OFF_RH:  rd_mux = {30'h0, ten ? res_q[9:8] : 2'h0};
      `ARC_OFF_RL:  rd_mux = {24'h0, res_q[7:0]};
      `ARC_OFF_CVH: rd_mux = {30'h0, cvh_q};
      `ARC_OFF_CVL: rd_mux = {24'h0, cvl_q};
      `ARC_OFF_CFG: rd_mux = {28'h0, mode_q, 2'h0};
      default:      rd_mux = 32'h0;
    endcase
  end

  // Zero wait states, so read data is caught at the address phase
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      req_q    <= '0;
      dphase_q <= 1'b0;
      rdata_q  <= 32'h0;
    end else begin
      dphase_q <= addr_ok;
      if (addr_ok) begin
        req_q.addr <= a_addr;
        req_q.wr   <= HWRITE_IN;
      end
      if (rd_now) begin
        rdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ch_q   <= `ARC_CH_RST;
      ctl_q  <= '0;
      mode_q <= `ARC_MODE_8;
      ten_q  <= 1'b0;
      cvh_q  <= 2'h0;
      cvl_q  <= 8'h0;
    end else if (dphase_q && req_q.wr) begin
      if (wr_sc1) begin
        ch_q <= HWDATA_IN[4:0];
      end
      if (wr_sc2) begin
        ctl_q <= HWDATA_IN[6:4];
      end
      if (wr_cfg) begin
        mode_q <= HWDATA_IN[3:2];
        ten_q  <= mode_ten(HWDATA_IN[3:2]);
      end
      if (req_q.addr == `ARC_OFF_CVH) begin
        cvh_q <= HWDATA_IN[1:0];
      end
      if (req_q.addr == `ARC_OFF_CVL) begin
        cvl_q <= HWDATA_IN[7:0];
      end
    end
  end

  // Trigger pin is asynchronous to the bus clock
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      trig_s1_q <= HW_TRIGGER_IN;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      start_q  <= 1'b0;
      abort_q  <= 1'b0;
      active_q <= 1'b0;
    end else begin
      start_q <= go;
      abort_q <= wr_sc1 && active_q;
      if (go) begin
        active_q <= 1'b1;
      end else if (wr_sc1 || done_ok) begin
        active_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      done_flag_q <= 1'b0;
    end else begin
      done_flag_q <= load || (done_flag_q && !wr_sc1 && !rd_lo);
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      lock_q <= 1'b0;
    end else if (rd_lo || !ten || (wr_cfg && HWDATA_IN[3:2] != mode_q)) begin
      lock_q <= 1'b0;
    end else if (rd_hi) begin
      lock_q <= 1'b1;
    end
  end

  // stale data kept after mode change
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      res_q <= 10'h0;
    end else if (xfer) begin
      res_q <= ten ? CONV_RESULT_IN : {2'h0, CONV_RESULT_IN[7:0]};
    end
  end

  assign HRDATA_OUT      = rdata_q;
  assign CONV_START_OUT  = start_q;
  assign CONV_ABORT_OUT  = abort_q;
  assign CONV_ACTIVE_OUT = active_q;
  assign CHANNEL_OUT     = ch_q;
  assign MODE_TEN_OUT    = ten_q;

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      HREADYOUT_OUT <= 1'b0;
      HRESP_OUT     <= 1'b0;
    end else begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end
  end

  active_set_a: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    go |=> (active_q && start_q))
    else $error("start did not raise active");

  active_clr_a: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    (done_ok && !go) |=> !active_q)
    else $error("active stayed after completion");

  sw_start_a: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    (wr_sc1 && !ctl_q.tsel && HWDATA_IN[4:0] != `ARC_CH_OFF) |=> start_q)
    else $error("software write did not start");

  hw_gate_a: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    (hw_edge && !ctl_q.tsel && !wr_sc1) |=> !start_q)
    else $error("hardware trigger started in software mode");

  cmp_off_a: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    (done_ok && !ctl_q.cmp_en) |=> done_flag_q)
    else $error("completion flag missed with compare off");

  ge_load_a: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    (done_ok && ctl_q.cmp_en && ctl_q.ge && ten && !lock_q &&
     CONV_RESULT_IN >= {cvh_q, cvl_q}) |=> res_q == $past(CONV_RESULT_IN))
    else $error("greater-equal result not loaded");

  lt_hold_a: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    (done_ok && ctl_q.cmp_en && !ctl_q.ge && ten &&
     CONV_RESULT_IN >= {cvh_q, cvl_q}) |=> res_q == $past(res_q))
    else $error("unmet less-than compare loaded result");

  lock_set_a: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    (rd_hi && ten && !wr_cfg) |=> lock_q)
    else $error("high read did not lock results");

  lock_hold_a: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    (lock_q && ten && done_ok) |=> res_q == $past(res_q))
    else $error("locked result overwritten");

  high_zero_a: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    (rd_hi && !ten) |=> HRDATA_OUT[1:0] == 2'h0)
    else $error("high result not zero in 8-bit mode");

endmodule

/* File: src/arc_defines.svh */
`ifndef ARC_DEFINES_SVH
`define ARC_DEFINES_SVH
`define ARC_OFF_SC1    8'h00
`define ARC_OFF_SC2    8'h04
`define ARC_OFF_RH     8'h08
`define ARC_OFF_RL     8'h0c
`define ARC_OFF_CVH    8'h10
`define ARC_OFF_CVL    8'h14
`define ARC_OFF_CFG    8'h18
`define ARC_BIT_ACTIVE 7
`define ARC_BIT_DONE   7
`define ARC_BIT_TSEL   6
`define ARC_BIT_CMPEN  5
`define ARC_BIT_GE     4
`define ARC_CH_OFF     5'h1f
`define ARC_MODE_8     2'h0
`define ARC_MODE_10    2'h2
`define ARC_CH_RST     5'h1f
`endif

/* File: src/arc_pkg.sv */
package arc_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
  } arc_req_t;
  typedef struct packed {
    logic       tsel;
    logic       cmp_en;
    logic       ge;
  } arc_ctl_t;
endpackage

/* File: verification/arc_conv_model.sv */
`timescale 1ns/100ps
module arc_conv_model (
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic       start_in,
  input  wire logic       abort_in,
  input  wire logic [9:0] value_in,
  input  wire logic [3:0] delay_in,
  output logic            done_out,
  output logic      [9:0] result_out
);
  logic [3:0] cnt_q;
  logic       busy_q;
  logic [9:0] last_q;
  // Released result bus shows the inverse, so stale data never matches
  assign result_out = done_out ? last_q : ~last_q;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      done_out <= 1'b0;
      last_q <= 10'h000;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        busy_q <= 1'b1;
        cnt_q <= delay_in;
      end else if (abort_in) begin
        busy_q <= 1'b0;
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q <= 1'b0;
        done_out <= 1'b1;
        last_q <= value_in;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule

/* File: verification/tb.sv */
`timescale 1ns/100ps
`include "arc_defines.svh"
module tb;
  logic        clk, rstn, hsel, hwr, trg, done, act, rdy, st, ab, ten, resp;
  logic [1:0]  htr;
  logic [4:0]  ch;
  logic [3:0]  dly;
  logic [9:0]  cval, cres, res_m, cv;
  logic [31:0] ha, hwd, hrd, rd, r;
  logic [7:0]  sc2;
  logic        lock_m, done_m, ten_m, val_m;
  int          err_total, num_checks, cyc, seed, i, n_ab;
  always #5 clk = ~clk;
  arc_top i_arc_top (.CLK_IN(clk), .RESETN_IN(rstn), .HSEL_IN(hsel), .HADDR_IN(ha),
    .HTRANS_IN(htr), .HWRITE_IN(hwr), .HSIZE_IN(3'h2), .HWDATA_IN(hwd), .HREADY_IN(rdy),
    .HRDATA_OUT(hrd), .HREADYOUT_OUT(rdy), .HRESP_OUT(resp), .HW_TRIGGER_IN(trg),
    .CONV_DONE_IN(done), .CONV_RESULT_IN(cres), .CONV_START_OUT(st), .CONV_ABORT_OUT(ab),
    .CONV_ACTIVE_OUT(act), .CHANNEL_OUT(ch), .MODE_TEN_OUT(ten));
  arc_conv_model i_arc_conv_model (.clk_in(clk), .rstn_in(rstn), .start_in(st),
    .abort_in(ab), .value_in(cval), .delay_in(dly), .done_out(done), .result_out(cres));
  task results();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (ab === 1'b1) n_ab++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htr <= 2'h2;
    ha <= {24'h0, a};
    hwr <= w;
    do @(posedge clk); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htr <= 2'h0;
    hwd <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = hrd;
    if (w && a == `ARC_OFF_SC1) done_m = 1'b0;
    if (!w && a == `ARC_OFF_RH && ten_m) lock_m = 1'b1;
    if (!w && a == `ARC_OFF_RL) begin
      lock_m = 1'b0;
      done_m = 1'b0;
    end
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  function automatic void model(logic [9:0] x);
    logic [9:0] n, c;
    logic       met;
    n = ten_m ? x : {2'h0, x[7:0]};
    c = ten_m ? cv : {2'h0, cv[7:0]};
    met = !sc2[5] || (sc2[4] ? n >= c : n < c);
    if (met) done_m = 1'b1;
    if (met && !lock_m) begin
      res_m = n;
      val_m = 1'b1;
    end
  endfunction
  task mode(input logic t);
    ahb(1'b1, `ARC_OFF_CFG, t ? 32'h8 : 32'h0);
    ten_m = t;
    lock_m = 1'b0;
    val_m = 1'b0;
    @(posedge clk);
    chk({31'h0, ten}, {31'h0, t});
  endtask
  task conv(input logic hw, input logic [9:0] x);
    r = $random(seed);
    cval <= x;
    dly <= {1'b0, r[2:0]};
    if (hw) begin
      @(posedge clk);
      trg <= 1'b1;
      repeat (10) begin
        @(posedge clk);
        if (act === 1'b1) break;
      end
      trg <= 1'b0;
    end else ahb(1'b1, `ARC_OFF_SC1, 32'h3);
    repeat (40) begin
      @(posedge clk);
      if (act === 1'b0) break;
    end
    model(x);
    repeat (2) @(posedge clk);
  endtask
  task post();
    rc(`ARC_OFF_SC1, {24'h0, done_m, 7'h03});
    if (val_m) rc(`ARC_OFF_RH, {30'h0, res_m[9:8]});
    ahb(1'b0, `ARC_OFF_RL, 32'h0);
    if (val_m) chk(rd, {24'h0, res_m[7:0]});
  endtask
  initial begin
    {clk, rstn, hsel, hwr, trg, htr, ha, hwd, cval, dly, sc2, cv} = '0;
    {lock_m, done_m, ten_m, val_m, err_total, num_checks, cyc, n_ab} = '0;
    seed = 32'h0f12fdd6;
    repeat (10) @(posedge clk);
    chk({27'h0, ch}, 32'h1f);
    rstn <= 1'b1;
    rc(`ARC_OFF_SC2, 32'h0);
    rc(8'h1c, 32'h0);
    mode(1'b1);
    for (i = 0; i < 16; i++) begin
      r = $random(seed);
      cv = r[9:0];
      ahb(1'b1, `ARC_OFF_CVH, {30'h0, cv[9:8]});
      ahb(1'b1, `ARC_OFF_CVL, {24'h0, cv[7:0]});
      rc(`ARC_OFF_CVH, {30'h0, cv[9:8]});
      sc2 = {1'b0, i[2], i[0], i[1], 4'h0};
      ahb(1'b1, `ARC_OFF_SC2, {24'h0, sc2});
      rc(`ARC_OFF_SC2, {24'h0, sc2});
      if (i == 8) mode(1'b0);
      r = $random(seed);
      conv(sc2[6], (i % 3 == 0) ? cv : r[9:0]);
      post();
    end
    sc2 = 8'h00;
    ahb(1'b1, `ARC_OFF_SC2, 32'h0);
    mode(1'b1);
    conv(1'b0, 10'h2a5);
    ahb(1'b0, `ARC_OFF_RH, 32'h0);
    conv(1'b0, 10'h15a);
    rc(`ARC_OFF_RL, {24'h0, res_m[7:0]});
    conv(1'b0, 10'h3c3);
    post();
    mode(1'b0);
    conv(1'b0, 10'h2a5);
    ahb(1'b0, `ARC_OFF_RH, 32'h0);
    conv(1'b0, 10'h15a);
    rc(`ARC_OFF_RL, {24'h0, res_m[7:0]});
    rc(`ARC_OFF_RH, 32'h0);
    dly <= 4'hf;
    ahb(1'b1, `ARC_OFF_SC1, 32'h3);
    ahb(1'b1, `ARC_OFF_SC1, 32'h5);
    @(negedge clk);
    chk({31'h0, act}, 32'h1);
    chk({27'h0, ch}, 32'h5);
    ahb(1'b1, `ARC_OFF_SC1, 32'h1f);
    repeat (20) @(posedge clk);
    chk({31'h0, act}, 32'h0);
    rc(`ARC_OFF_SC1, {24'h0, done_m, 7'h1f});
    chk(n_ab, 32'h2);
    ahb(1'b1, `ARC_OFF_CFG, 32'hc);
    @(negedge clk);
    chk({31'h0, ten}, 32'h0);
    chk({31'h0, resp}, 32'h0);
    results();
  end
endmodule
